// File: hw/tmrb_pkg.sv
// Constants and helpers for the temperature monitor register bank.
// Assumes one clock, a synchronous active-high reset and a byte-wide
// front end that has already decoded the two-wire serial protocol.
package tmrb_pkg;
  localparam int NCH = 3;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_HYST = 8'h21;
  localparam logic [7:0] IDX_SW_RST = 8'hFC;
  // Per channel: local, remote1, remote2
  localparam logic [7:0] TEMP_HI_IDX [NCH] = '{8'h00, 8'h01, 8'h23};
  localparam logic [7:0] TEMP_LO_IDX [NCH] = '{8'h29, 8'h10, 8'h24};
  localparam logic [7:0] HLIM_HI_WR [NCH] = '{8'h0B, 8'h0D, 8'h15};
  localparam logic [7:0] HLIM_HI_RD [NCH] = '{8'h05, 8'h07, 8'h15};
  localparam logic [7:0] HLIM_LO_IDX [NCH] = '{8'h3D, 8'h13, 8'h17};
  localparam logic [7:0] LLIM_HI_WR [NCH] = '{8'h0C, 8'h0E, 8'h16};
  localparam logic [7:0] LLIM_HI_RD [NCH] = '{8'h06, 8'h08, 8'h16};
  localparam logic [7:0] LLIM_LO_IDX [NCH] = '{8'h3E, 8'h14, 8'h18};
  localparam logic [7:0] THERM_IDX [NCH] = '{8'h20, 8'h19, 8'h1A};
  // Reset values
  localparam logic [7:0] HLIM_HI_RST = 8'h55;
  localparam logic [3:0] HLIM_LO_RST = 4'h0;
  localparam logic [7:0] LLIM_HI_RST = 8'h00;
  localparam logic [3:0] LLIM_LO_RST = 4'h0;
  localparam logic [7:0] THERM_RST = 8'h55;
  localparam logic [7:0] HYST_RST = 8'h0A;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [11:0] RESULT_RST = 12'h000;
  // Low bytes carry their four fraction bits in D7..D4
  localparam logic [3:0] LO_PAD = 4'h0;
  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_LOCAL_OVER_HIGH_FLAG = 6;
  localparam int ST_LOCAL_UNDER_LOW_FLAG = 5;
  localparam int ST_REMOTE_OVER_HIGH_FLAG = 4;
  localparam int ST_REMOTE_UNDER_LOW_FLAG = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_RTHERM = 1;
  localparam int ST_LTHERM = 0;

  typedef enum logic [1:0] {RK_OTHER, RK_HIGH, RK_LOW} tmrb_rdkind_t;

  // Index of the second byte of a two-byte transfer
  function automatic logic [7:0] tmrb_pair_idx(input logic [7:0] idx);
    logic [7:0] r;
    r = idx;
    for (int ch = 0; ch < NCH; ch++) begin
      if (idx == TEMP_HI_IDX[ch]) r = TEMP_LO_IDX[ch];
      if (idx == HLIM_HI_WR[ch] || idx == HLIM_HI_RD[ch]) r = HLIM_LO_IDX[ch];
      if (idx == LLIM_HI_WR[ch] || idx == LLIM_HI_RD[ch]) r = LLIM_LO_IDX[ch];
    end
    return r;
  endfunction : tmrb_pair_idx
endpackage : tmrb_pkg

// File: hw/tmrb_snap_if.sv
// Link between the register bank and its result/snapshot store.
// Assumes both ends share the bank clock.
`timescale 1ns/1ps
`default_nettype none
interface tmrb_snap_if;
  logic conv_done;
  logic [1:0] conv_ch;
  logic [11:0] conv_result;
  logic rd_stb;
  logic [1:0] rd_ch;
  tmrb_pkg::tmrb_rdkind_t rd_kind;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  modport bank (
    output conv_done, conv_ch, conv_result, rd_stb, rd_ch, rd_kind,
    input res_hi, res_lo
  );
  modport snap (
    input conv_done, conv_ch, conv_result, rd_stb, rd_ch, rd_kind,
    output res_hi, res_lo
  );
endinterface : tmrb_snap_if
`default_nettype wire

// File: hw/tmrb_snapshot.sv
// Temperature result store with the high/low read snapshot.
// Assumes reads are strobed one byte at a time by the bank.
`timescale 1ns/1ps
`default_nettype none
module tmrb_snapshot (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bank side
  tmrb_snap_if.snap sif
);
  logic [11:0] res_reg [tmrb_pkg::NCH];
  logic [3:0] snap_lo_reg;
  logic [1:0] snap_ch_reg;
  logic snap_vld_reg;
  logic ch_ok;
  logic [11:0] res_sel;

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < tmrb_pkg::NCH; i++) res_reg[i] <= tmrb_pkg::RESULT_RST;
    end else if (sif.conv_done && sif.conv_ch < 2'(tmrb_pkg::NCH)) begin
      res_reg[sif.conv_ch] <= sif.conv_result;
    end
  end

  // freeze low nibble at high-byte read
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_vld_reg <= 1'b0;
      snap_lo_reg <= 4'h0;
      snap_ch_reg <= 2'h0;
    end else if (sif.rd_stb) begin
      snap_vld_reg <= (sif.rd_kind == tmrb_pkg::RK_HIGH);
      snap_lo_reg <= res_sel[3:0];
      snap_ch_reg <= sif.rd_ch;
    end
  end

  // Live value, replaced by the frozen nibble while the snapshot holds
  assign ch_ok = sif.rd_ch < 2'(tmrb_pkg::NCH);
  assign res_sel = ch_ok ? res_reg[sif.rd_ch] : tmrb_pkg::RESULT_RST;
  assign sif.res_hi = res_sel[11:4];
  assign sif.res_lo = (snap_vld_reg && snap_ch_reg == sif.rd_ch) ?
    {snap_lo_reg, tmrb_pkg::LO_PAD} : {res_sel[3:0], tmrb_pkg::LO_PAD};
endmodule : tmrb_snapshot
`default_nettype wire

// File: hw/tmrb_register_bank.sv
// Register bank of a three-channel temperature monitor.
// Assumes a serial front end that strobes index loads, data bytes
// and read requests, and a converter that pulses finished results.
`timescale 1ns/1ps
`default_nettype none
module tmrb_register_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Index load from each write command
  input wire logic ptr_load,
  input wire logic [7:0] ptr_data,
  // Data byte written
  input wire logic wr_byte,
  input wire logic wr_second,
  input wire logic [7:0] wr_data,
  // Data byte read
  input wire logic rd_byte,
  input wire logic rd_second,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Converter results
  input wire logic conv_done,
  input wire logic [1:0] conv_ch,
  input wire logic [11:0] conv_result,
  // Status sources
  input wire logic busy,
  input wire logic local_over_high_flag,
  input wire logic local_under_low_flag,
  input wire logic remote_over_high_flag,
  input wire logic remote_under_low_flag,
  input wire logic open_diode_flag,
  input wire logic remote_overtemp_flag,
  input wire logic local_overtemp_flag,
  // Settings to the comparators
  output logic [11:0] high_limit [tmrb_pkg::NCH],
  output logic [11:0] low_limit [tmrb_pkg::NCH],
  output logic [7:0] therm_limit [tmrb_pkg::NCH],
  output logic [7:0] hysteresis,
  // Events and state
  output logic [7:0] reg_index,
  output logic status_read,
  output logic soft_reset
);
  logic [7:0] ptr_reg;
  logic [7:0] status_reg;
  logic [7:0] hyst_reg;
  logic [11:0] hlim_reg [tmrb_pkg::NCH];
  logic [11:0] llim_reg [tmrb_pkg::NCH];
  logic [7:0] therm_reg [tmrb_pkg::NCH];
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic status_read_reg;
  logic soft_rst_reg;
  logic bank_rst;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [1:0] rd_ch;
  tmrb_pkg::tmrb_rdkind_t rd_kind;

  tmrb_snap_if sif ();

  // Soft reset lands one cycle after the write, like a power-on
  assign bank_rst = sys_rst | soft_rst_reg;

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      ptr_reg <= tmrb_pkg::PTR_RST;
    end else if (ptr_load) begin
      ptr_reg <= ptr_data;
    end
  end

  // Second byte of a two-byte transfer goes to the partner low byte.
  // The index itself is left alone, so a repeated read starts over.
  assign wr_idx = wr_second ? tmrb_pkg::tmrb_pair_idx(ptr_reg) : ptr_reg;
  assign rd_idx = rd_second ? tmrb_pkg::tmrb_pair_idx(ptr_reg) : ptr_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_byte && !soft_rst_reg &&
        (wr_idx == tmrb_pkg::IDX_SW_RST);
    end
  end

  // Limit and THERM registers, one copy per channel
  for (genvar g = 0; g < tmrb_pkg::NCH; g++) begin : g_chan
    always_ff @(posedge clk) begin
      if (bank_rst) begin
        hlim_reg[g] <= {tmrb_pkg::HLIM_HI_RST, tmrb_pkg::HLIM_LO_RST};
      end else if (wr_byte) begin
        if (wr_idx == tmrb_pkg::HLIM_HI_WR[g]) begin
          hlim_reg[g][11:4] <= wr_data;
        end
        if (wr_idx == tmrb_pkg::HLIM_LO_IDX[g]) begin
          hlim_reg[g][3:0] <= wr_data[7:4];
        end
      end
    end

    always_ff @(posedge clk) begin
      if (bank_rst) begin
        llim_reg[g] <= {tmrb_pkg::LLIM_HI_RST, tmrb_pkg::LLIM_LO_RST};
      end else if (wr_byte) begin
        if (wr_idx == tmrb_pkg::LLIM_HI_WR[g]) begin
          llim_reg[g][11:4] <= wr_data;
        end
        if (wr_idx == tmrb_pkg::LLIM_LO_IDX[g]) begin
          llim_reg[g][3:0] <= wr_data[7:4];
        end
      end
    end

    always_ff @(posedge clk) begin
      if (bank_rst) begin
        therm_reg[g] <= tmrb_pkg::THERM_RST;
      end else if (wr_byte && wr_idx == tmrb_pkg::THERM_IDX[g]) begin
        therm_reg[g] <= wr_data;
      end
    end

    // Stored limits feed the comparators directly.
    // range change needs rewrite
    assign high_limit[g] = hlim_reg[g];
    assign low_limit[g] = llim_reg[g];
    assign therm_limit[g] = therm_reg[g];
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      hyst_reg <= tmrb_pkg::HYST_RST;
    end else if (wr_byte && wr_idx == tmrb_pkg::IDX_HYST) begin
      hyst_reg <= wr_data;
    end
  end

  assign hysteresis = hyst_reg;

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      status_reg <= tmrb_pkg::STATUS_RST;
    end else begin
      status_reg[tmrb_pkg::ST_BUSY] <= busy;
      status_reg[tmrb_pkg::ST_LOCAL_OVER_HIGH_FLAG] <= local_over_high_flag;
      status_reg[tmrb_pkg::ST_LOCAL_UNDER_LOW_FLAG] <= local_under_low_flag;
      status_reg[tmrb_pkg::ST_REMOTE_OVER_HIGH_FLAG] <= remote_over_high_flag;
      status_reg[tmrb_pkg::ST_REMOTE_UNDER_LOW_FLAG] <= remote_under_low_flag;
      status_reg[tmrb_pkg::ST_OPEN] <= open_diode_flag;
      status_reg[tmrb_pkg::ST_RTHERM] <= remote_overtemp_flag;
      status_reg[tmrb_pkg::ST_LTHERM] <= local_overtemp_flag;
    end
  end

  // Which result byte, if any, the read index selects
  always_comb begin
    rd_ch = 2'h0;
    rd_kind = tmrb_pkg::RK_OTHER;
    for (int ch = 0; ch < tmrb_pkg::NCH; ch++) begin
      if (rd_idx == tmrb_pkg::TEMP_HI_IDX[ch]) begin
        rd_ch = 2'(ch);
        rd_kind = tmrb_pkg::RK_HIGH;
      end
      if (rd_idx == tmrb_pkg::TEMP_LO_IDX[ch]) begin
        rd_ch = 2'(ch);
        rd_kind = tmrb_pkg::RK_LOW;
      end
    end
  end

  // Result store; any read other than a high byte drops the snapshot
  assign sif.conv_done = conv_done;
  assign sif.conv_ch = conv_ch;
  assign sif.conv_result = conv_result;
  assign sif.rd_stb = rd_byte;
  assign sif.rd_ch = rd_ch;
  assign sif.rd_kind = rd_kind;

  tmrb_snapshot u_snap (
    .clk(clk),
    .rst(bank_rst),
    .sif(sif.snap)
  );

  // Read data selection; limit write indices read the limit high byte, unmapped indices and FCh read 00h
  always_comb begin
    rd_data_next = 8'h00;
    unique case (rd_kind)
      tmrb_pkg::RK_HIGH: begin
        rd_data_next = sif.res_hi;
      end
      tmrb_pkg::RK_LOW: begin
        rd_data_next = sif.res_lo;
      end
      tmrb_pkg::RK_OTHER: begin
        if (rd_idx == tmrb_pkg::IDX_STATUS) rd_data_next = status_reg;
        if (rd_idx == tmrb_pkg::IDX_HYST) rd_data_next = hyst_reg;
        for (int ch = 0; ch < tmrb_pkg::NCH; ch++) begin
          if (rd_idx == tmrb_pkg::HLIM_HI_RD[ch] ||
              rd_idx == tmrb_pkg::HLIM_HI_WR[ch]) begin
            rd_data_next = hlim_reg[ch][11:4];
          end
          if (rd_idx == tmrb_pkg::HLIM_LO_IDX[ch]) begin
            rd_data_next = {hlim_reg[ch][3:0], tmrb_pkg::LO_PAD};
          end
          if (rd_idx == tmrb_pkg::LLIM_HI_RD[ch] ||
              rd_idx == tmrb_pkg::LLIM_HI_WR[ch]) begin
            rd_data_next = llim_reg[ch][11:4];
          end
          if (rd_idx == tmrb_pkg::LLIM_LO_IDX[ch]) begin
            rd_data_next = {llim_reg[ch][3:0], tmrb_pkg::LO_PAD};
          end
          if (rd_idx == tmrb_pkg::THERM_IDX[ch]) begin
            rd_data_next = therm_reg[ch];
          end
        end
      end
      default: begin
        rd_data_next = 8'h00;
      end
    endcase
  end

  // Read answer registered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_byte;
      if (rd_byte) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  // Status-read event for the flag latches outside this bank
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      status_read_reg <= 1'b0;
    end else begin
      status_read_reg <= rd_byte && (rd_idx == tmrb_pkg::IDX_STATUS);
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign reg_index = ptr_reg;
  assign status_read = status_read_reg;
  assign soft_reset = soft_rst_reg;
endmodule : tmrb_register_bank
`default_nettype wire

// File: sim/tmrb_props.sv
// Checker on the bank ports: index, read answer, status and soft reset.
// Assumes one clock and the synchronous reset of the bank.
`timescale 1ns/1ps
`default_nettype none
module tmrb_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Requests
  input wire logic ptr_load,
  input wire logic [7:0] ptr_data,
  input wire logic wr_byte,
  input wire logic [7:0] wr_data,
  input wire logic rd_byte,
  // Answers and state
  input wire logic rd_valid,
  input wire logic [7:0] hysteresis,
  input wire logic [7:0] reg_index,
  input wire logic status_read,
  input wire logic soft_reset
);
  // Requests in the soft reset cycle are lost, so each rule on a request leaves it out
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_index_load: assert property (
    ptr_load && !soft_reset |=> reg_index == $past(ptr_data)) else $error("index not loaded");
  a_index_hold: assert property (
    !ptr_load && !soft_reset |=> $stable(reg_index)) else $error("index moved");
  a_read_answer: assert property (
    rd_byte && !soft_reset |=> rd_valid) else $error("read not answered");
  a_answer_cause: assert property (
    rd_valid |-> $past(rd_byte)) else $error("answer without read");
  a_status_read: assert property (
    rd_byte && reg_index == 8'h02 && !soft_reset |=> status_read) else $error("no status event");
  a_soft_start: assert property (
    wr_byte && reg_index == 8'hFC && !soft_reset |=> soft_reset) else $error("no soft reset");
  a_soft_clear: assert property (
    soft_reset |=> reg_index == 8'h00 && hysteresis == 8'h0A) else $error("state not cleared");
  a_hyst_write: assert property (
    wr_byte && reg_index == 8'h21 && !soft_reset |=> hysteresis == $past(wr_data))
    else $error("hysteresis not written");
endmodule : tmrb_props
bind tmrb_register_bank tmrb_props chk_u (.clk, .sys_rst, .ptr_load, .ptr_data, .wr_byte,
  .wr_data, .rd_byte, .rd_valid, .hysteresis, .reg_index, .status_read, .soft_reset);
`default_nettype wire

// File: sim/tmrb_host.sv
// Host controller model issuing index loads, writes and reads.
// Assumes the bank clock; drives just after each falling edge.
`timescale 1ns/1ps
`default_nettype none
module tmrb_host (
  // Clock
  input wire logic clk,
  // Index and write strobes
  output logic ptr_load,
  output logic [7:0] ptr_data,
  output logic wr_byte,
  output logic wr_second,
  output logic [7:0] wr_data,
  // Read strobes and answer
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic rd_byte,
  output logic rd_second
);
  // Idle bus at time zero
  initial begin
    {ptr_load, wr_byte, wr_second, rd_byte, rd_second} = 5'h00;
    ptr_data = 8'h00;
    wr_data = 8'h00;
  end
  // index before access; released data changes so it is never reused
  task automatic set_idx(input logic [7:0] idx);
    @(negedge clk);
    ptr_load = 1'b1;
    ptr_data = idx;
    @(negedge clk);
    ptr_load = 1'b0;
    ptr_data = ~idx;
  endtask : set_idx
  // High byte first on two-byte writes
  task automatic wr(input int n, input logic [15:0] d);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      wr_byte = 1'b1;
      wr_second = (i == 1);
      wr_data = (n == 2 && i == 0) ? d[15:8] : d[7:0];
    end
    @(negedge clk);
    wr_byte = 1'b0;
    wr_data = ~wr_data;
  endtask : wr
  // high then low; a missing answer shows as unknown
  task automatic rd(input int n, output logic [15:0] d);
    d = 16'h0000;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      if (i > 0) d = {d[7:0], rd_valid ? rd_data : 8'hXX};
      rd_byte = (i < n);
      rd_second = (i == 1) && (i < n);
    end
  endtask : rd
endmodule : tmrb_host
`default_nettype wire

// File: sim/tmrb_register_bank_tb.sv
// Self-checking bench for the register bank through the host model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module tmrb_register_bank_tb;
  logic clk, sys_rst, conv_done, ptr_load, wr_byte, wr_second, rd_byte, rd_second;
  logic rd_valid, status_read, soft_reset;
  logic [1:0] conv_ch;
  logic [11:0] conv_result, r;
  logic [7:0] st, ptr_data, wr_data, rd_data, hysteresis, reg_index;
  logic [11:0] hl [tmrb_pkg::NCH];
  logic [11:0] ll [tmrb_pkg::NCH];
  logic [7:0] tl [tmrb_pkg::NCH];
  logic [15:0] d, v;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Reset image: index in the high byte, value in the low; 50h is unmapped
  logic [15:0] rst_tab [24] = '{16'h0000, 16'h0100, 16'h0200, 16'h0555, 16'h0600,
    16'h0755, 16'h0800, 16'h1000, 16'h1300, 16'h1400, 16'h1555, 16'h1600, 16'h1700,
    16'h1800, 16'h1955, 16'h1A55, 16'h2055, 16'h210A, 16'h2300, 16'h2400, 16'h2900,
    16'h3D00, 16'h3E00, 16'h5000};
  // Limits: write, read and low byte index; even rows are high limits
  logic [7:0] lim [6][3] = '{'{8'h0B, 8'h05, 8'h3D}, '{8'h0C, 8'h06, 8'h3E},
    '{8'h0D, 8'h07, 8'h13}, '{8'h0E, 8'h08, 8'h14}, '{8'h15, 8'h15, 8'h17},
    '{8'h16, 8'h16, 8'h18}};
  // Result indices per channel, then the single-byte settings
  logic [7:0] thi [3] = '{8'h00, 8'h01, 8'h23};
  logic [7:0] tlo [3] = '{8'h29, 8'h10, 8'h24};
  logic [7:0] one [4] = '{8'h20, 8'h19, 8'h1A, 8'h21};

  tmrb_host host_u (.clk, .ptr_load, .ptr_data, .wr_byte, .wr_second, .wr_data, .rd_byte,
    .rd_second, .rd_data, .rd_valid);
  tmrb_register_bank dut_u (.clk, .sys_rst, .ptr_load, .ptr_data, .wr_byte, .wr_second,
    .wr_data, .rd_byte, .rd_second, .rd_data, .rd_valid, .conv_done, .conv_ch, .conv_result,
    .busy(st[7]), .local_over_high_flag(st[6]), .local_under_low_flag(st[5]),
    .remote_over_high_flag(st[4]), .remote_under_low_flag(st[3]), .open_diode_flag(st[2]),
    .remote_overtemp_flag(st[1]), .local_overtemp_flag(st[0]), .high_limit(hl),
    .low_limit(ll), .therm_limit(tl), .hysteresis, .reg_index, .status_read, .soft_reset);

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic get(input logic [7:0] idx, input int n);
    host_u.set_idx(idx);
    host_u.rd(n, d);
  endtask : get
  task automatic put(input logic [7:0] idx, input int n, input logic [15:0] val);
    host_u.set_idx(idx);
    host_u.wr(n, val);
  endtask : put
  task automatic conv(input logic [1:0] ch, input logic [11:0] res);
    @(negedge clk);
    conv_done = 1'b1;
    conv_ch = ch;
    conv_result = res;
    @(negedge clk);
    conv_done = 1'b0;
  endtask : conv
  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    st = 8'h00;
    conv_done = 1'b0;
    conv_ch = 2'h0;
    conv_result = 12'h000;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk(reg_index, 16'h0000);
    foreach (rst_tab[i]) begin
      get(rst_tab[i][15:8], 1);
      chk(d, rst_tab[i][7:0]);
    end
    // pair write, read at both indices
    // every limit is written in full before it is relied on
    for (int i = 0; i < 6; i++) begin
      v = 16'h31A7 + 16'(i) * 16'h0110;
      put(lim[i][0], 2, v);
      get(lim[i][1], 2);
      chk(d, v & 16'hFFF0);
      chk(i[0] ? ll[i/2] : hl[i/2], v[15:4]);
      put(lim[i][2], 1, 16'h0055);
      get(lim[i][2], 1);
      chk(d, 16'h0050);
      get(lim[i][0], 1);
      chk(d, {8'h00, v[15:8]});
    end
    foreach (one[i]) begin
      put(one[i], 1, 16'h0040 + 16'(i));
      get(one[i], 1);
      chk(d, 16'h0040 + 16'(i));
    end
    chk(tl[0], 16'h0040);
    chk(tl[1], 16'h0041);
    chk(tl[2], 16'h0042);
    // snapshot kept across a newer result, dropped by another read
    for (int c = 0; c < 3; c++) begin
      r = 12'h5A3 + 12'(c) * 12'h111;
      conv(2'(c), r);
      put(thi[c], 1, 16'h00FF);
      get(thi[c], 1);
      chk(d, r[11:4]);
      conv(2'(c), ~r);
      get(tlo[c], 1);
      chk(d, {r[3:0], 4'h0});
      conv(2'd3, r);
      get(thi[c], 2);
      chk(d, {~r, 4'h0});
      get(thi[c], 1);
      get(8'h02, 1);
      conv(2'(c), r);
      get(tlo[c], 1);
      chk(d, {r[3:0], 4'h0});
    end
    st = 8'hA5;
    get(8'h02, 1);
    chk(d, 16'h00A5);
    st = 8'h5A;
    get(8'h02, 1);
    chk(d, 16'h005A);
    put(8'h21, 1, 16'h0033);
    put(8'hFC, 1, 16'h00C3);
    repeat (2) @(negedge clk);
    chk(reg_index, 16'h0000);
    get(8'h21, 1);
    chk(d, 16'h000A);
    get(8'h01, 1);
    chk(d, 16'h0000);
    end_sim();
  end
endmodule : tmrb_register_bank_tb
`default_nettype wire
